/* File: rtl/wkt_pkg.sv */
// Constants and types shared by the wake-up timer design
package wkt_pkg;

	// ************************************************************
	// Register map: indices, byte address is four times the index
	// ************************************************************
	localparam int         ADDR_W           = 12;
	localparam int         IDX_LSB          = 2;
	localparam logic [7:0] IDX_CONTROL      = 8'h23;
	localparam logic [7:0] IDX_RELOAD_HIGH  = 8'h24;
	localparam logic [7:0] IDX_RELOAD_LOW   = 8'h25;
	localparam logic [7:0] IDX_COUNT_HIGH   = 8'h26;
	localparam logic [7:0] IDX_COUNT_LOW    = 8'h27;
	localparam logic [7:0] IDX_EVENT_STATUS = 8'h30;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int CTL_RUN_BIT    = 7;
	localparam int CTL_QUAL_BIT   = 6;
	localparam int CTL_TRIM_BIT   = 5;
	localparam int CTL_DETECT_BIT = 4;
	localparam int CTL_RELOAD_BIT = 3;
	localparam int CTL_WAKE_BIT   = 2;
	localparam int CTL_CLK_MSB    = 1;
	localparam int ST_TIMER_IRQ   = 0;
	localparam int ST_CARD_IRQ    = 1;
	localparam int ST_SEQ_BUSY    = 2;

	// ************************************************************
	// Reset values and encodings
	// ************************************************************
	localparam logic [5:0]  CONTROL_RESET = 6'h00;
	localparam logic [15:0] RELOAD_RESET  = 16'h0000;
	localparam logic [15:0] COUNT_RESET   = 16'h0000;
	localparam logic [15:0] COUNT_LAST    = 16'h0001;
	localparam logic [1:0]  CLK_SEL_DIV1  = 2'h0;
	localparam logic [1:0]  CLK_SEL_DIV8  = 2'h1;
	localparam logic [1:0]  CLK_SEL_DIV16 = 2'h2;
	localparam logic [1:0]  CLK_SEL_DIV32 = 2'h3;
	localparam logic [4:0]  PRE_MASK_DIV1  = 5'h00;
	localparam logic [4:0]  PRE_MASK_DIV8  = 5'h07;
	localparam logic [4:0]  PRE_MASK_DIV16 = 5'h0f;
	localparam logic [4:0]  PRE_MASK_DIV32 = 5'h1f;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_TRIM, SEQ_DETECT} wkt_seq_t;

endpackage

/* File: rtl/wkt_reg_if.sv */
// Register access carrier between bus slave and timer core
`timescale 1ns/1ps
interface wkt_reg_if;
	logic       wrStb;
	logic [7:0] wrIdx;
	logic [7:0] wrData;
	logic       wrHit;
	logic [7:0] rdIdx;
	logic [7:0] rdData;
	logic       rdHit;

	modport bus  (output wrStb, wrIdx, wrData, rdIdx, input wrHit, rdData, rdHit);
	modport regs (input wrStb, wrIdx, wrData, rdIdx, output wrHit, rdData, rdHit);
endinterface

/* File: rtl/wkt_prescaler.sv */
// Oscillator input synchroniser and selectable divider
`timescale 1ns/1ps
module wkt_prescaler (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       lfOscIn,
	input  wire logic [1:0] clockSelect,
	output logic            tick
);
	logic [2:0] syncReg;
	logic [4:0] divReg;
	logic [4:0] divNext;
	logic [4:0] mask;
	logic       oscEdge;

	// Rising edge while the second stage holds the new level and the third still holds the old one
	assign oscEdge = syncReg[1] & ~syncReg[2];

	always_comb begin
		case (clockSelect)
			wkt_pkg::CLK_SEL_DIV1:  mask = wkt_pkg::PRE_MASK_DIV1;
			wkt_pkg::CLK_SEL_DIV8:  mask = wkt_pkg::PRE_MASK_DIV8;
			wkt_pkg::CLK_SEL_DIV16: mask = wkt_pkg::PRE_MASK_DIV16;
			default:                mask = wkt_pkg::PRE_MASK_DIV32;
		endcase
		divNext = oscEdge ? divReg + 5'h01 : divReg;
		tick    = oscEdge && ((divReg & mask) == mask);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			syncReg <= 3'h0;
			divReg  <= 5'h00;
		end else begin
			syncReg <= {syncReg[1:0], lfOscIn};
			divReg  <= divNext;
		end
	end
endmodule

/* File: rtl/wkt_axil_slave.sv */
// AXI4-Lite slave feeding the register carrier
`timescale 1ns/1ps
module wkt_axil_slave (
	input  wire logic                       sys_clk,
	input  wire logic                       rst_n,
	input  wire logic [wkt_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                       awvalid,
	output logic                            awready,
	input  wire logic [31:0]                wdata,
	input  wire logic [3:0]                 wstrb,
	input  wire logic                       wvalid,
	output logic                            wready,
	output logic [1:0]                      bresp,
	output logic                            bvalid,
	input  wire logic                       bready,
	input  wire logic [wkt_pkg::ADDR_W-1:0] araddr,
	input  wire logic                       arvalid,
	output logic                            arready,
	output logic [31:0]                     rdata,
	output logic [1:0]                      rresp,
	output logic                            rvalid,
	input  wire logic                       rready,
	wkt_reg_if.bus                          regs
);
	logic                       awHeldReg, awHeldNext, wHeldReg, wHeldNext;
	logic [wkt_pkg::ADDR_W-1:0] awAddrReg, awAddrNext;
	logic [7:0]                 wDataReg, wDataNext;
	logic                       wLaneReg, wLaneNext;
	logic                       bValidReg, bValidNext, rValidReg, rValidNext;
	logic [1:0]                 bRespReg, bRespNext, rRespReg, rRespNext;
	logic [7:0]                 rDataReg, rDataNext;
	logic                       wrAlign, rdAlign;

	assign awready = !awHeldReg && !bValidReg;
	assign wready  = !wHeldReg && !bValidReg;
	assign arready = !rValidReg;
	assign bvalid  = bValidReg;
	assign bresp   = bRespReg;
	assign rvalid  = rValidReg;
	assign rresp   = rRespReg;
	assign rdata   = {24'h000000, rDataReg};

	assign wrAlign     = (awAddrReg[1:0] == 2'h0) && (awAddrReg[wkt_pkg::ADDR_W-1:10] == '0);
	assign rdAlign     = (araddr[1:0] == 2'h0) && (araddr[wkt_pkg::ADDR_W-1:10] == '0);
	assign regs.wrIdx  = awAddrReg[9:wkt_pkg::IDX_LSB];
	assign regs.wrData = wDataReg;
	assign regs.rdIdx  = araddr[9:wkt_pkg::IDX_LSB];
	// Store only when both halves are held, the low lane is enabled and the address is sane
	assign regs.wrStb  = awHeldReg && wHeldReg && !bValidReg && wLaneReg && wrAlign;

	always_comb begin
		awHeldNext = awHeldReg;
		awAddrNext = awAddrReg;
		wHeldNext  = wHeldReg;
		wDataNext  = wDataReg;
		wLaneNext  = wLaneReg;
		bValidNext = bValidReg && !bready;
		bRespNext  = bRespReg;
		rValidNext = rValidReg && !rready;
		rRespNext  = rRespReg;
		rDataNext  = rDataReg;
		if (awvalid && awready) begin
			awHeldNext = 1'b1;
			awAddrNext = awaddr;
		end
		if (wvalid && wready) begin
			wHeldNext = 1'b1;
			wDataNext = wdata[7:0];
			wLaneNext = wstrb[0];
		end
		if (awHeldReg && wHeldReg && !bValidReg) begin
			awHeldNext = 1'b0;
			wHeldNext  = 1'b0;
			bValidNext = 1'b1;
			bRespNext  = (wrAlign && regs.wrHit) ? wkt_pkg::RESP_OKAY : wkt_pkg::RESP_SLVERR;
		end
		if (arvalid && arready) begin
			rValidNext = 1'b1;
			rDataNext  = (rdAlign && regs.rdHit) ? regs.rdData : 8'h00;
			rRespNext  = (rdAlign && regs.rdHit) ? wkt_pkg::RESP_OKAY : wkt_pkg::RESP_SLVERR;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			awHeldReg <= 1'b0;
			awAddrReg <= '0;
			wHeldReg  <= 1'b0;
			wDataReg  <= 8'h00;
			wLaneReg  <= 1'b0;
			bValidReg <= 1'b0;
			bRespReg  <= 2'h0;
			rValidReg <= 1'b0;
			rRespReg  <= 2'h0;
			rDataReg  <= 8'h00;
		end else begin
			awHeldReg <= awHeldNext;
			awAddrReg <= awAddrNext;
			wHeldReg  <= wHeldNext;
			wDataReg  <= wDataNext;
			wLaneReg  <= wLaneNext;
			bValidReg <= bValidNext;
			bRespReg  <= bRespNext;
			rValidReg <= rValidNext;
			rRespReg  <= rRespNext;
			rDataReg  <= rDataNext;
		end
	end
endmodule

/* File: rtl/wkt_top.sv */
// Wake-up timer core with register file, sequencer and bus slave
//
// Notes on behaviour
// - Running flag reads high while counting, low while stopped.
// - A write changes the running flag only when the same write sets the qualifier bit.
// - With auto-trim set, every underflow that finds the sequencer idle launches an oscillator trimming run.
// - With auto card-detect set, every underflow that finds the sequencer idle starts a card detection sequence.
// - Card found raises an interrupt request and keeps the system active.
// - No card found enters power-down when that is enabled.
// - During auto card detection the countdown restarts at once after underflow.
// - Timer 3 times the probing field; it cannot trim in parallel.
// - With auto-reload set, count reloads at zero and keeps counting.
// - With auto-reload and auto card-detect clear, count stops at zero and running flag drops.
// - Every underflow sets the timer interrupt flag.
// - With auto-wake set, every underflow wakes the chip.
// - Clock select 00 undivided, 01 by 8, 10 by 16, 11 by 32.
// - Counter and reload value are 16 bits; reload split in two bytes.
// - Each start event loads the counter from both reload bytes.
// - Reload writes while running leave the count in progress alone.
// - Live count readable as high and low byte.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module wkt_top (
	input  wire logic                       sys_clk,
	input  wire logic                       rst_n,
	input  wire logic [wkt_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                       awvalid,
	output logic                            awready,
	input  wire logic [31:0]                wdata,
	input  wire logic [3:0]                 wstrb,
	input  wire logic                       wvalid,
	output logic                            wready,
	output logic [1:0]                      bresp,
	output logic                            bvalid,
	input  wire logic                       bready,
	input  wire logic [wkt_pkg::ADDR_W-1:0] araddr,
	input  wire logic                       arvalid,
	output logic                            arready,
	output logic [31:0]                     rdata,
	output logic [1:0]                      rresp,
	output logic                            rvalid,
	input  wire logic                       rready,
	input  wire logic                       lfOscIn,
	input  wire logic                       trimDone,
	input  wire logic                       t3FieldDone,
	input  wire logic                       cardPresent,
	output logic                            timerRunning,
	output logic                            timerIrq,
	output logic                            cardIrq,
	output logic                            trimStart,
	output logic                            fieldProbeEn,
	output logic                            wakeUp,
	output logic                            powerDownReq
);
	wkt_reg_if regBus ();

	logic [5:0]        ctlReg, ctlNext;
	logic [15:0]       reloadReg, reloadNext;
	logic [15:0]       countReg, countNext;
	logic              runReg, runNext;
	logic              timerIrqReg, timerIrqNext;
	logic              cardIrqReg, cardIrqNext;
	wkt_pkg::wkt_seq_t seqReg, seqNext;
	logic              detectAfterReg, detectAfterNext;
	logic              trimStartReg, trimStartNext;
	logic              wakeReg, wakeNext;
	logic              pdReg, pdNext;
	logic              lfTick;
	logic              ctlWrite, statusWrite;
	logic              startEv, stopEv, underflow;
	logic              autoTrim, autoDetect, autoReload, autoWake;
	logic              cardFound;

	// ************************************************************
	// Bus slave and input divider
	// ************************************************************
	wkt_axil_slave u_wkt_axil_slave (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.regs    (regBus.bus)
	);

	wkt_prescaler u_wkt_prescaler (
		.sys_clk     (sys_clk),
		.rst_n       (rst_n),
		.lfOscIn     (lfOscIn),
		.clockSelect (ctlReg[wkt_pkg::CTL_CLK_MSB:0]),
		.tick        (lfTick)
	);

	assign autoTrim   = ctlReg[wkt_pkg::CTL_TRIM_BIT];
	assign autoDetect = ctlReg[wkt_pkg::CTL_DETECT_BIT];
	assign autoReload = ctlReg[wkt_pkg::CTL_RELOAD_BIT];
	assign autoWake   = ctlReg[wkt_pkg::CTL_WAKE_BIT];

	assign ctlWrite    = regBus.wrStb && (regBus.wrIdx == wkt_pkg::IDX_CONTROL);
	assign statusWrite = regBus.wrStb && (regBus.wrIdx == wkt_pkg::IDX_EVENT_STATUS);

	// ************************************************************
	// Register writes and read multiplexer
	// ************************************************************
	always_comb begin
		ctlNext    = ctlReg;
		reloadNext = reloadReg;
		if (ctlWrite) begin
			ctlNext = regBus.wrData[5:0];
		end
		// Reload bytes only feed the counter at a start or reload
		if (regBus.wrStb && regBus.wrIdx == wkt_pkg::IDX_RELOAD_HIGH) begin
			reloadNext[15:8] = regBus.wrData;
		end
		if (regBus.wrStb && regBus.wrIdx == wkt_pkg::IDX_RELOAD_LOW) begin
			reloadNext[7:0] = regBus.wrData;
		end
	end

	always_comb begin
		regBus.rdHit = 1'b1;
		case (regBus.rdIdx)
			wkt_pkg::IDX_CONTROL:      regBus.rdData = {runReg, 1'b0, ctlReg};
			wkt_pkg::IDX_RELOAD_HIGH:  regBus.rdData = reloadReg[15:8];
			wkt_pkg::IDX_RELOAD_LOW:   regBus.rdData = reloadReg[7:0];
			wkt_pkg::IDX_COUNT_HIGH:   regBus.rdData = countReg[15:8];
			wkt_pkg::IDX_COUNT_LOW:    regBus.rdData = countReg[7:0];
			wkt_pkg::IDX_EVENT_STATUS: regBus.rdData = {5'h00, seqReg != wkt_pkg::SEQ_IDLE,
			                                            cardIrqReg, timerIrqReg};
			default: begin
				regBus.rdData = 8'h00;
				regBus.rdHit  = 1'b0;
			end
		endcase
		case (regBus.wrIdx)
			wkt_pkg::IDX_CONTROL, wkt_pkg::IDX_RELOAD_HIGH, wkt_pkg::IDX_RELOAD_LOW,
			wkt_pkg::IDX_COUNT_HIGH, wkt_pkg::IDX_COUNT_LOW,
			wkt_pkg::IDX_EVENT_STATUS: regBus.wrHit = 1'b1;
			default:                   regBus.wrHit = 1'b0;
		endcase
	end

	// ************************************************************
	// Down-counter
	// ************************************************************
	always_comb begin
		startEv   = ctlWrite && regBus.wrData[wkt_pkg::CTL_QUAL_BIT]
		            && regBus.wrData[wkt_pkg::CTL_RUN_BIT] && !runReg;
		stopEv    = ctlWrite && regBus.wrData[wkt_pkg::CTL_QUAL_BIT]
		            && !regBus.wrData[wkt_pkg::CTL_RUN_BIT];
		countNext = countReg;
		runNext   = runReg;
		underflow = 1'b0;
		if (startEv) begin
			countNext = reloadReg;
			runNext   = 1'b1;
		end else if (stopEv) begin
			runNext = 1'b0;
		end else if (runReg && lfTick) begin
			if (countReg <= wkt_pkg::COUNT_LAST) begin
				underflow = 1'b1;
				if (autoReload || autoDetect) begin
					countNext = reloadReg;
				end else begin
					countNext = wkt_pkg::COUNT_RESET;
					runNext   = 1'b0;
				end
			end else begin
				countNext = countReg - wkt_pkg::COUNT_LAST;
			end
		end
	end

	// ************************************************************
	// Event flags, set wins over write-one-to-clear
	// ************************************************************
	always_comb begin
		timerIrqNext = timerIrqReg;
		cardIrqNext  = cardIrqReg;
		if (statusWrite && regBus.wrData[wkt_pkg::ST_TIMER_IRQ]) begin
			timerIrqNext = 1'b0;
		end
		if (statusWrite && regBus.wrData[wkt_pkg::ST_CARD_IRQ]) begin
			cardIrqNext = 1'b0;
		end
		if (underflow) begin
			timerIrqNext = 1'b1;
		end
		if (cardFound) begin
			cardIrqNext = 1'b1;
		end
	end

	// ************************************************************
	// Trimming and card detection sequencer
	// ************************************************************
	always_comb begin
		seqNext         = seqReg;
		detectAfterNext = detectAfterReg;
		trimStartNext   = 1'b0;
		pdNext          = 1'b0;
		cardFound       = 1'b0;
		wakeNext        = underflow && autoWake;
		case (seqReg)
			wkt_pkg::SEQ_IDLE: begin
				if (underflow && autoTrim) begin
					seqNext         = wkt_pkg::SEQ_TRIM;
					trimStartNext   = 1'b1;
					detectAfterNext = autoDetect;
				end else if (underflow && autoDetect) begin
					seqNext = wkt_pkg::SEQ_DETECT;
				end
			end
			wkt_pkg::SEQ_TRIM: begin
				if (trimDone) begin
					if (detectAfterReg) begin
						seqNext = wkt_pkg::SEQ_DETECT;
					end else begin
						seqNext = wkt_pkg::SEQ_IDLE;
						pdNext  = autoWake;
					end
				end
			end
			wkt_pkg::SEQ_DETECT: begin
				// Field stays on until Timer 3 reports its end
				if (t3FieldDone) begin
					seqNext   = wkt_pkg::SEQ_IDLE;
					cardFound = cardPresent;
					pdNext    = !cardPresent && autoWake;
				end
			end
			default: begin
				seqNext = wkt_pkg::SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctlReg         <= wkt_pkg::CONTROL_RESET;
			reloadReg      <= wkt_pkg::RELOAD_RESET;
			countReg       <= wkt_pkg::COUNT_RESET;
			runReg         <= 1'b0;
			timerIrqReg    <= 1'b0;
			cardIrqReg     <= 1'b0;
			seqReg         <= wkt_pkg::SEQ_IDLE;
			detectAfterReg <= 1'b0;
			trimStartReg   <= 1'b0;
			wakeReg        <= 1'b0;
			pdReg          <= 1'b0;
		end else begin
			ctlReg         <= ctlNext;
			reloadReg      <= reloadNext;
			countReg       <= countNext;
			runReg         <= runNext;
			timerIrqReg    <= timerIrqNext;
			cardIrqReg     <= cardIrqNext;
			seqReg         <= seqNext;
			detectAfterReg <= detectAfterNext;
			trimStartReg   <= trimStartNext;
			wakeReg        <= wakeNext;
			pdReg          <= pdNext;
		end
	end

	assign timerRunning = runReg;
	assign timerIrq     = timerIrqReg;
	assign cardIrq      = cardIrqReg;
	assign trimStart    = trimStartReg;
	assign fieldProbeEn = (seqReg == wkt_pkg::SEQ_DETECT);
	assign wakeUp       = wakeReg;
	assign powerDownReq = pdReg;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	property p_run_qualifier;
		ctlWrite && !regBus.wrData[wkt_pkg::CTL_QUAL_BIT] && !lfTick |=> $stable(timerRunning);
	endproperty
	a_run_qualifier: assert property (p_run_qualifier)
		else $error("running flag changed without qualifier");

	property p_oneshot_stop;
		underflow && !autoReload && !autoDetect |=> !timerRunning && countReg == 16'h0000;
	endproperty
	a_oneshot_stop: assert property (p_oneshot_stop)
		else $error("one-shot timer did not stop at zero");

	property p_auto_restart;
		underflow && (autoReload || autoDetect) |=> timerRunning && countReg == $past(reloadReg);
	endproperty
	a_auto_restart: assert property (p_auto_restart)
		else $error("timer did not reload after underflow");

	property p_irq_set;
		underflow |=> timerIrq ##1 (timerIrq || $past(statusWrite));
	endproperty
	a_irq_set: assert property (p_irq_set)
		else $error("underflow did not raise timer flag");

	property p_wake_pulse;
		underflow && autoWake |=> wakeUp ##1 !wakeUp || $past(underflow);
	endproperty
	a_wake_pulse: assert property (p_wake_pulse)
		else $error("wake pulse missing after underflow");

	property p_trim_launch;
		underflow && autoTrim && seqReg == wkt_pkg::SEQ_IDLE |=> trimStart && !fieldProbeEn;
	endproperty
	a_trim_launch: assert property (p_trim_launch)
		else $error("trim run not launched");

	property p_detect_launch;
		underflow && autoDetect && !autoTrim && seqReg == wkt_pkg::SEQ_IDLE |=> fieldProbeEn;
	endproperty
	a_detect_launch: assert property (p_detect_launch)
		else $error("card detection not started");

	property p_trim_then_detect;
		seqReg == wkt_pkg::SEQ_TRIM && trimDone && detectAfterReg |=> fieldProbeEn && !powerDownReq;
	endproperty
	a_trim_then_detect: assert property (p_trim_then_detect)
		else $error("detection skipped after trim");

	property p_card_found;
		fieldProbeEn && t3FieldDone && cardPresent |=> cardIrq && !powerDownReq && !fieldProbeEn;
	endproperty
	a_card_found: assert property (p_card_found)
		else $error("found card not reported");

	property p_no_card;
		fieldProbeEn && t3FieldDone && !cardPresent && autoWake |=> powerDownReq ##1 !powerDownReq;
	endproperty
	a_no_card: assert property (p_no_card)
		else $error("power-down not requested without card");

	property p_reload_hold;
		runReg && !lfTick && !startEv && !stopEv |=> countReg == $past(countReg);
	endproperty
	a_reload_hold: assert property (p_reload_hold)
		else $error("count moved without tick");

	property p_decrement;
		runReg && lfTick && !startEv && !stopEv && countReg > 16'h0001
			|=> countReg == $past(countReg) - 16'h0001;
	endproperty
	a_decrement: assert property (p_decrement)
		else $error("count did not decrement by one");

	c_underflow:    cover property (underflow ##1 timerIrq);
	c_card_found:   cover property (fieldProbeEn && t3FieldDone && cardPresent);
	c_trim_detect:  cover property (seqReg == wkt_pkg::SEQ_TRIM ##[1:200] fieldProbeEn);
	c_power_down:   cover property (powerDownReq);
endmodule

/* File: tb/wkt_top_tb.sv */
// Self-checking bench for the wake-up timer top
`timescale 1ns/1ps
module wkt_top_tb;
	logic        sys_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic        lfOscIn, trimDone, t3FieldDone, cardPresent;
	logic        timerRunning, timerIrq, cardIrq, trimStart, fieldProbeEn, wakeUp, powerDownReq;
	logic [15:0] rl, c;
	int          fails = 0, checksDone = 0, nTrim = 0, nWake = 0, nPd = 0;

	wkt_top u_wkt_top (.sys_clk(sys_clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.lfOscIn(lfOscIn), .trimDone(trimDone), .t3FieldDone(t3FieldDone),
		.cardPresent(cardPresent), .timerRunning(timerRunning), .timerIrq(timerIrq),
		.cardIrq(cardIrq), .trimStart(trimStart), .fieldProbeEn(fieldProbeEn),
		.wakeUp(wakeUp), .powerDownReq(powerDownReq));

	initial sys_clk = 1'b0;
	always #12.5 sys_clk = ~sys_clk;

	// Pulse outputs counted as they pass
	always @(posedge sys_clk) begin
		nTrim <= nTrim + int'(trimStart === 1'b1);
		nWake <= nWake + int'(wakeUp === 1'b1);
		nPd   <= nPd + int'(powerDownReq === 1'b1);
	end

	// ************************************************************
	// Bench tasks
	// ************************************************************
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		@(posedge sys_clk);
		awaddr  <= {2'h0, idx, 2'h0};
		wdata   <= {24'h0, v};
		wstrb   <= 4'h1;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (awready !== 1'b1 && awvalid || wready !== 1'b1 && wvalid);
		do @(posedge sys_clk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] idx, output logic [31:0] v, output logic [1:0] e);
		@(posedge sys_clk);
		araddr  <= {2'h0, idx, 2'h0};
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge sys_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge sys_clk); while (rvalid !== 1'b1);
		v = rdata;
		e = rresp;
		rready <= 1'b0;
	endtask

	task automatic rdCount(output logic [15:0] v);
		rd(wkt_pkg::IDX_COUNT_HIGH, d, r);
		v[15:8] = d[7:0];
		rd(wkt_pkg::IDX_COUNT_LOW, d, r);
		v[7:0] = d[7:0];
	endtask

	task automatic osc(input int n);
		repeat (n) begin
			lfOscIn <= 1'b1;
			repeat (4) @(posedge sys_clk);
			lfOscIn <= 1'b0;
			repeat (4) @(posedge sys_clk);
		end
	endtask

	task automatic pulse(input int which, input logic card);
		trimDone    <= (which == 0);
		t3FieldDone <= (which == 1);
		cardPresent <= card;
		@(posedge sys_clk);
		trimDone    <= 1'b0;
		t3FieldDone <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask

	task automatic seqRun(input logic card, input int k);
		osc(1);
		chk("trimStart", nTrim, k);
		chk("running", timerRunning, 1'b1);
		pulse(0, 1'b0);
		chk("fieldProbeEn", fieldProbeEn, 1'b1);
		pulse(1, card);
		chk("fieldOff", fieldProbeEn, 1'b0);
		chk("cardIrq", cardIrq, card);
		chk("powerDown", nPd, 1);
	endtask

	function automatic logic [15:0] expCount(logic [15:0] v, int p, int sel);
		return v - 16'(p / (sel == 0 ? 1 : 4 << sel));
	endfunction

	task final_report;
		if (fails == 0 && checksDone > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready, lfOscIn} = '0;
		{trimDone, t3FieldDone, cardPresent, awaddr, araddr, wdata, wstrb} = '0;
		void'($urandom(32'h6cfb));
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(wkt_pkg::IDX_CONTROL, d, r);
		chk("controlReset", d, 32'h0);
		rdCount(c);
		chk("countReset", c, 16'h0);
		rd(8'h10, d, r);
		chk("unmappedData", d, 32'h0);
		chk("unmappedResp", r, wkt_pkg::RESP_SLVERR);
		wr(8'h10, 8'h55);
		chk("unmappedWrResp", r, wkt_pkg::RESP_SLVERR);
		for (int s = 0; s < 4; s++) begin
			rl = {8'h01, 8'($urandom)};
			wr(wkt_pkg::IDX_RELOAD_HIGH, rl[15:8]);
			wr(wkt_pkg::IDX_RELOAD_LOW, rl[7:0]);
			wr(wkt_pkg::IDX_CONTROL, 8'h80 | 8'(s));
			chk("noQualifier", timerRunning, 1'b0);
			wr(wkt_pkg::IDX_CONTROL, 8'hc0 | 8'(s));
			chk("started", timerRunning, 1'b1);
			rd(wkt_pkg::IDX_CONTROL, d, r);
			chk("runFlag", d, 32'h80 | 32'(s));
			wr(wkt_pkg::IDX_CONTROL, 8'(s));
			chk("noQualStop", timerRunning, 1'b1);
			rdCount(c);
			chk("loaded", c, rl);
			wr(wkt_pkg::IDX_RELOAD_LOW, ~rl[7:0]);
			rd(wkt_pkg::IDX_RELOAD_LOW, d, r);
			chk("reloadLow", d, {24'h0, ~rl[7:0]});
			osc(32);
			wr(wkt_pkg::IDX_CONTROL, 8'h40 | 8'(s));
			rdCount(c);
			chk("divided", c, expCount(rl, 32, s));
		end
		// One-shot countdown
		wr(wkt_pkg::IDX_RELOAD_HIGH, 8'h00);
		wr(wkt_pkg::IDX_RELOAD_LOW, 8'h03);
		wr(wkt_pkg::IDX_CONTROL, 8'hc0);
		osc(3);
		chk("oneShotStop", timerRunning, 1'b0);
		chk("timerIrq", timerIrq, 1'b1);
		rdCount(c);
		chk("oneShotZero", c, 16'h0);
		wr(wkt_pkg::IDX_EVENT_STATUS, 8'h01);
		chk("writeOkResp", r, wkt_pkg::RESP_OKAY);
		chk("irqCleared", timerIrq, 1'b0);
		// Auto reload with wake
		wr(wkt_pkg::IDX_RELOAD_LOW, 8'h02);
		wr(wkt_pkg::IDX_CONTROL, 8'hcc);
		osc(2);
		chk("reloadRun", timerRunning, 1'b1);
		rdCount(c);
		chk("reloaded", c, 16'h2);
		chk("wakeUp", nWake, 1);
		chk("irqAgain", timerIrq, 1'b1);
		wr(wkt_pkg::IDX_CONTROL, 8'h40);
		// Trim then card detection, twice
		wr(wkt_pkg::IDX_RELOAD_LOW, 8'h01);
		wr(wkt_pkg::IDX_CONTROL, 8'hf4);
		seqRun(1'b0, 1);
		seqRun(1'b1, 2);
		// Detection alone, auto-wake cleared
		wr(wkt_pkg::IDX_EVENT_STATUS, 8'h02);
		chk("cardIrqCleared", cardIrq, 1'b0);
		wr(wkt_pkg::IDX_CONTROL, 8'hd0);
		osc(1);
		chk("noTrim", nTrim, 2);
		chk("detectOnly", fieldProbeEn, 1'b1);
		rd(wkt_pkg::IDX_EVENT_STATUS, d, r);
		chk("seqBusy", d, 32'h5);
		pulse(1, 1'b0);
		chk("stayActive", nPd, 1);
		chk("noWake", nWake, 3);
		final_report();
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		final_report();
	end
endmodule
